// file: design/option_word_pkg.sv
package option_word_pkg;
   // register byte offsets on the AXI4-Lite slave
   localparam int ADDR_W = 5;
   localparam logic [4:0] ADDR_INSTR = 5'h00;
   localparam logic [4:0] ADDR_STATUS = 5'h04;
   localparam logic [4:0] ADDR_CONFIG = 5'h08;
   localparam logic [4:0] ADDR_RETIRED = 5'h0C;
   // option word bit positions
   localparam int OPT_CLK_BIT = 0;
   localparam int OPT_MS_BIT = 1;
   localparam int OPT_HLF_BIT = 2;
   localparam int OPT_VOLTAGE_LEVEL_SELECT_BIT = 3;
   localparam int OPT_WDT_BIT = 4;
   localparam int OPT_TYPE_BIT = 5;
   localparam int OPT_RSV_BIT = 6;
   // instruction issue register layout
   localparam int INSTR_W = 13;
   localparam int SKIP_BIT = 16;
   // status register fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_VALID_BIT = 1;
   localparam int ST_FAULT_BIT = 2;
   localparam int ST_CYC_LSB = 4;
   // config register fields
   localparam int CF_LEN4_BIT = 0;
   localparam int CF_MODE_LSB = 1;
   localparam int CF_WDT_BIT = 3;
   localparam int CF_LVL_BIT = 4;
   localparam int CF_PKG_BIT = 5;
   // oscillator mode codes shown in the config register
   localparam logic [1:0] MODE_RC = 2'h0;
   localparam logic [1:0] MODE_LOW = 2'h1;
   localparam logic [1:0] MODE_HIGH = 2'h2;
   // register-file address of the program counter
   localparam logic [5:0] PC_REG_ADDR = 6'h02;
   // fixed opcodes without operand fields
   localparam logic [12:0] OP_RET = 13'h0012;
   localparam logic [12:0] OP_RETURN_FROM_INTERRUPT = 13'h0013;
   localparam logic [12:0] OP_TABLE = 13'h0020;
   localparam logic [12:0] OP_INT = 13'h1E02;
   // instruction cycle counts
   localparam logic [1:0] CYCLES_ONE = 2'h1;
   localparam logic [1:0] CYCLES_TWO = 2'h2;
   // oscillator periods per instruction cycle, as last divider index
   localparam logic [1:0] LAST_PHASE_SHORT = 2'h1;
   localparam logic [1:0] LAST_PHASE_LONG = 2'h3;
   // option capture sequence after reset release
   localparam logic [1:0] LOAD_SAMPLE = 2'h2;
   localparam logic [1:0] LOAD_DONE = 2'h3;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // sequencer states, gray along idle-align-first-second
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_ALIGN = 2'b01,
      SEQ_FIRST = 2'b11,
      SEQ_SECOND = 2'b10
   } seq_state_type;

   // instruction cycles an instruction occupies
   function automatic logic [1:0] cycle_count(input logic [12:0] ins, input logic skipTrue);
      logic [1:0] n;
      logic toPc;
      n = CYCLES_ONE;
      toPc = (ins[5:0] == PC_REG_ADDR);
      if (ins[12]) begin
         // call, jump, return with literal, software interrupt
         if (!ins[11] || ins[11:8] == 4'hC || ins == OP_INT) begin
            n = CYCLES_TWO;
         end
      end else if (ins == OP_RET || ins == OP_RETURN_FROM_INTERRUPT || ins == OP_TABLE) begin
         n = CYCLES_TWO;
      end else if (ins[11]) begin
         // bit clear/set on the pc, or a bit test whose skip is taken
         if ((!ins[10] && toPc) || (ins[10] && skipTrue)) begin
            n = CYCLES_TWO;
         end
      end else if (ins[6] && toPc) begin
         n = CYCLES_TWO;
      end else if ((ins[10:8] == 3'h5 || ins[10:8] == 3'h7) && ins[7] && skipTrue) begin
         n = CYCLES_TWO;
      end
      return n;
   endfunction : cycle_count
endpackage : option_word_pkg

// file: design/cycle_divider.sv
// splits the oscillator into instruction cycles of two or four periods
module cycle_divider (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // control
   input wire logic run,
   input wire logic cycleLen4,
   // one-cycle pulse per instruction cycle
   output logic cycleEnd
);
   import option_word_pkg::*;

   logic [1:0] phase_reg; // oscillator period within the cycle
   logic [1:0] lastPhase; // final period index for this setting

   assign lastPhase = cycleLen4 ? LAST_PHASE_LONG : LAST_PHASE_SHORT; // RL9

   // phase counter, parked at zero until configuration is valid
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         phase_reg <= 2'h0;
      end else if (!run || phase_reg == lastPhase) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   // pulse one clock after the last period, so the period is exact
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cycleEnd <= 1'b0;
      end else begin
         cycleEnd <= run && (phase_reg == lastPhase); // RL13
      end
   end
endmodule : cycle_divider

// file: design/option_word_cycle_timing.sv
// Behaviour
// [RL1] option word unreachable by the running program
// [RL2] bit 6 reserved must be one; bit 7 ignored
// [RL3] bit 5 picks package: one means small
// [RL4] bit 4 low enables the watchdog
// [RL5] bit 3 one selects power-saving voltage level
// [RL6] bit 2 one high crystal, zero low crystal
// [RL7] crystal range counts only in crystal mode
// [RL8] bit 1 zero RC, one crystal
// [RL9] bit 0 sets two or four periods/cycle
// [RL10] instructions are single 13-bit words
// [RL11] writes to pc take two cycles
// [RL12] jumps, calls, returns, taken skips take two
// [RL13] counter clock is osc/4 or osc/2
// [RL14] any bit of any register is bit-addressable
// [RL15] port registers decode like general registers
// [RL16] option captured at reset, then held constant
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
module option_word_cycle_timing (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // option word from the one-time fuses
   input wire logic [7:0] optionWord,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [option_word_pkg::ADDR_W-1:0] awaddr,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [option_word_pkg::ADDR_W-1:0] araddr,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // decoded configuration
   output logic configValid,
   output logic optionFault,
   output logic watchdogOn,
   output logic voltageLevelSelect,
   output logic packageSmall,
   output logic externalRcMode,
   output logic highCrystalMode,
   output logic lowCrystalMode,
   output logic cycleLen4,
   // real-time counter clock pulse
   output logic counterTick
);
   import option_word_pkg::*;

   // option word capture
   logic [7:0] optSync1_reg; // first sync stage, read only by the second
   logic [7:0] optSync2_reg; // settled copy of the fuse outputs
   logic [1:0] loadCnt_reg; // steps through capture after reset
   logic [1:0] modeCode; // mode as shown to software

   // bus slave state
   logic awHeld_reg; // write address taken, waiting for data
   logic [ADDR_W-1:0] awAddr_reg;
   logic wHeld_reg; // write data taken, waiting for address
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic doWrite; // both halves present, response not yet out
   logic issueOk; // the write starts an instruction
   logic [31:0] readWord; // read mux output

   // sequencer state
   seq_state_type state_reg;
   logic [INSTR_W-1:0] instr_reg; // last issued instruction word
   logic skipTrue_reg; // skip outcome supplied with it
   logic [1:0] need_reg; // instruction cycles it occupies
   logic [1:0] lastCycles_reg; // cycles the last instruction took
   logic [15:0] retired_reg; // completed instruction count
   logic seqDone; // last cycle of an instruction ends now

   // two-stage synchroniser; the fuses settle asynchronously
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         optSync1_reg <= 8'h00;
         optSync2_reg <= 8'h00;
      end else begin
         optSync1_reg <= optionWord;
         optSync2_reg <= optSync1_reg;
      end
   end

   // capture sequencer: sample once after release, then stop
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         loadCnt_reg <= 2'h0;
      end else if (loadCnt_reg != LOAD_DONE) begin
         loadCnt_reg <= loadCnt_reg + 2'h1; // RL16
      end
   end

   // decoded configuration latches, written only at the sample step;
   // bit 7 has no consumer at all
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         configValid <= 1'b0;
         optionFault <= 1'b0;
         watchdogOn <= 1'b0;
         voltageLevelSelect <= 1'b0;
         packageSmall <= 1'b0;
         externalRcMode <= 1'b0;
         highCrystalMode <= 1'b0;
         lowCrystalMode <= 1'b0;
         cycleLen4 <= 1'b0;
      end else if (loadCnt_reg == LOAD_SAMPLE) begin // RL16
         configValid <= 1'b1;
         // reserved bit low, or range set in RC mode, is a bad fuse image
         optionFault <= !optSync2_reg[OPT_RSV_BIT]
            || (!optSync2_reg[OPT_MS_BIT] && optSync2_reg[OPT_HLF_BIT]); // RL2 RL7
         watchdogOn <= !optSync2_reg[OPT_WDT_BIT]; // RL4
         voltageLevelSelect <= optSync2_reg[OPT_VOLTAGE_LEVEL_SELECT_BIT]; // RL5
         packageSmall <= optSync2_reg[OPT_TYPE_BIT]; // RL3
         externalRcMode <= !optSync2_reg[OPT_MS_BIT]; // RL8
         // range only matters once crystal operation is chosen
         highCrystalMode <= optSync2_reg[OPT_MS_BIT] && optSync2_reg[OPT_HLF_BIT]; // RL6 RL7
         lowCrystalMode <= optSync2_reg[OPT_MS_BIT] && !optSync2_reg[OPT_HLF_BIT]; // RL6 RL7
         cycleLen4 <= optSync2_reg[OPT_CLK_BIT]; // RL9
      end
   end

   // instruction cycle and counter clock from the oscillator
   cycle_divider divider (
      .mclk(mclk),
      .rst_b(rst_b),
      .run(configValid),
      .cycleLen4(cycleLen4),
      .cycleEnd(counterTick)
   );

   // write address channel
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         awready <= 1'b0;
         awHeld_reg <= 1'b0;
         awAddr_reg <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         awHeld_reg <= 1'b1;
         awAddr_reg <= awaddr;
      end else if (bvalid && bready) begin
         awready <= 1'b1;
         awHeld_reg <= 1'b0;
      end else if (!awHeld_reg && !bvalid) begin
         awready <= 1'b1;
      end
   end

   // write data channel, independent of the address channel
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wready <= 1'b0;
         wHeld_reg <= 1'b0;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         wHeld_reg <= 1'b1;
         wData_reg <= wdata;
         wStrb_reg <= wstrb;
      end else if (bvalid && bready) begin
         wready <= 1'b1;
         wHeld_reg <= 1'b0;
      end else if (!wHeld_reg && !bvalid) begin
         wready <= 1'b1;
      end
   end

   assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
   // an issue needs lanes 0..2, a valid config and an idle sequencer
   assign issueOk = doWrite && awAddr_reg == ADDR_INSTR && wStrb_reg[2:0] == 3'h7
      && configValid && state_reg == SEQ_IDLE;

   // write response; the option word has no writable address at all
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp <= issueOk ? RESP_OKAY : RESP_SLVERR; // RL1
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // read mux; only decoded state is visible, never the raw word
   always_comb begin
      readWord = 32'h0000_0000;
      case (araddr)
         ADDR_INSTR: begin
            readWord[INSTR_W-1:0] = instr_reg;
            readWord[SKIP_BIT] = skipTrue_reg;
         end
         ADDR_STATUS: begin
            readWord[ST_BUSY_BIT] = state_reg != SEQ_IDLE;
            readWord[ST_VALID_BIT] = configValid;
            readWord[ST_FAULT_BIT] = optionFault;
            readWord[ST_CYC_LSB +: 2] = lastCycles_reg;
         end
         ADDR_CONFIG: begin // RL1
            readWord[CF_LEN4_BIT] = cycleLen4;
            readWord[CF_MODE_LSB +: 2] = modeCode;
            readWord[CF_WDT_BIT] = watchdogOn;
            readWord[CF_LVL_BIT] = voltageLevelSelect;
            readWord[CF_PKG_BIT] = packageSmall;
         end
         ADDR_RETIRED: begin
            readWord[15:0] = retired_reg;
         end
         default: begin
            readWord = 32'h0000_0000;
         end
      endcase
   end

   assign modeCode = highCrystalMode ? MODE_HIGH : (lowCrystalMode ? MODE_LOW : MODE_RC);

   // read channel, one cycle from address to data
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= readWord;
         rresp <= (araddr[1:0] == 2'h0 && araddr <= ADDR_RETIRED) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // issued instruction; the 6-bit register field is decoded the same
   // for ports, the pc and general registers, so bit ops reach all
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         instr_reg <= 13'h0000;
         skipTrue_reg <= 1'b0;
         need_reg <= CYCLES_ONE;
      end else if (issueOk) begin
         instr_reg <= wData_reg[INSTR_W-1:0]; // RL10
         skipTrue_reg <= wData_reg[SKIP_BIT];
         need_reg <= cycle_count(wData_reg[INSTR_W-1:0], wData_reg[SKIP_BIT]); // RL14 RL15
      end
   end

   assign seqDone = counterTick && ((state_reg == SEQ_FIRST && need_reg == CYCLES_ONE)
      || state_reg == SEQ_SECOND);

   // sequencer; an instruction starts on the next cycle boundary
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= SEQ_IDLE;
      end else begin
         case (state_reg)
            SEQ_IDLE: begin
               if (issueOk) begin
                  state_reg <= SEQ_ALIGN;
               end
            end
            SEQ_ALIGN: begin
               if (counterTick) begin
                  state_reg <= SEQ_FIRST;
               end
            end
            SEQ_FIRST: begin
               if (counterTick) begin
                  // pc writes, branches and taken skips hold a second cycle
                  state_reg <= (need_reg == CYCLES_TWO) ? SEQ_SECOND : SEQ_IDLE; // RL11 RL12
               end
            end
            SEQ_SECOND: begin
               if (counterTick) begin
                  state_reg <= SEQ_IDLE;
               end
            end
            default: begin
               state_reg <= SEQ_IDLE;
            end
         endcase
      end
   end

   // completion bookkeeping
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lastCycles_reg <= 2'h0;
         retired_reg <= 16'h0000;
      end else if (seqDone) begin
         lastCycles_reg <= need_reg;
         retired_reg <= retired_reg + 16'h0001;
      end
   end

   // checks on configuration capture, counter clock, instruction cycle counts and bus writes
   a_cfg_held: assert property (@(posedge mclk) disable iff (!rst_b) // RL16
      $past(configValid) |-> $stable({watchdogOn, voltageLevelSelect, packageSmall,
         externalRcMode, highCrystalMode, lowCrystalMode, cycleLen4}))
      else $error("configuration changed after capture");
   a_rsv_fault: assert property (@(posedge mclk) disable iff (!rst_b) // RL2
      loadCnt_reg == LOAD_SAMPLE && !optSync2_reg[OPT_RSV_BIT] |=> optionFault)
      else $error("reserved bit low not flagged");
   a_pkg_sel: assert property (@(posedge mclk) disable iff (!rst_b) // RL3
      loadCnt_reg == LOAD_SAMPLE |=> packageSmall == $past(optSync2_reg[OPT_TYPE_BIT]))
      else $error("package select wrong");
   a_wdt_low: assert property (@(posedge mclk) disable iff (!rst_b) // RL4
      loadCnt_reg == LOAD_SAMPLE |=> watchdogOn != $past(optSync2_reg[OPT_WDT_BIT]))
      else $error("watchdog enable polarity wrong");
   a_lvl_sel: assert property (@(posedge mclk) disable iff (!rst_b) // RL5
      loadCnt_reg == LOAD_SAMPLE |=> voltageLevelSelect == $past(optSync2_reg[OPT_VOLTAGE_LEVEL_SELECT_BIT]))
      else $error("voltage level wrong");
   a_osc_mode: assert property (@(posedge mclk) disable iff (!rst_b) // RL6 RL7 RL8
      configValid |-> $onehot({externalRcMode, highCrystalMode, lowCrystalMode}))
      else $error("oscillator mode not one-hot");
   a_rc_range: assert property (@(posedge mclk) disable iff (!rst_b) // RL7
      loadCnt_reg == LOAD_SAMPLE && !optSync2_reg[OPT_MS_BIT] |=> externalRcMode
         && !highCrystalMode && optionFault == ($past(optSync2_reg[OPT_HLF_BIT])
         || !$past(optSync2_reg[OPT_RSV_BIT])))
      else $error("crystal range leaked into RC mode");
   a_tick_four: assert property (@(posedge mclk) disable iff (!rst_b) // RL13 RL9
      counterTick && cycleLen4 |=> !counterTick [*3] ##1 counterTick)
      else $error("counter clock not osc/4");
   a_tick_two: assert property (@(posedge mclk) disable iff (!rst_b) // RL13 RL9
      counterTick && !cycleLen4 |=> !counterTick ##1 counterTick)
      else $error("counter clock not osc/2");
   a_pc_len: assert property (@(posedge mclk) disable iff (!rst_b) // RL11 RL12
      seqDone |=> lastCycles_reg == cycle_count(instr_reg, skipTrue_reg))
      else $error("instruction length wrong");
   a_cfg_ro: assert property (@(posedge mclk) disable iff (!rst_b) // RL1
      doWrite && awAddr_reg != ADDR_INSTR |=> bvalid && bresp == RESP_SLVERR)
      else $error("write outside issue register accepted");

   c_two_cycle: cover property (@(posedge mclk) disable iff (!rst_b)
      seqDone && need_reg == CYCLES_TWO);
   c_one_cycle: cover property (@(posedge mclk) disable iff (!rst_b)
      seqDone && need_reg == CYCLES_ONE);
   c_long_cycle: cover property (@(posedge mclk) disable iff (!rst_b)
      counterTick && cycleLen4);
   c_busy_refuse: cover property (@(posedge mclk) disable iff (!rst_b)
      doWrite && awAddr_reg == ADDR_INSTR && state_reg != SEQ_IDLE);
endmodule : option_word_cycle_timing

// file: dv/option_fuse_model.sv
// stands in for the one-time fuse array that feeds the option word
module option_fuse_model (
   // pattern burnt by the programmer
   input wire logic [7:0] programmed,
   // pass the pattern unchecked, for fault scenarios only
   input wire logic rawMode,
   // fuse outputs toward the device
   output logic [7:0] optionWord
);
   timeunit 1ns;
   timeprecision 1ps;

   // a careful programmer keeps the reserved bit set and the range bit clear in rc mode
   always_comb begin
      optionWord = programmed;
      if (!rawMode) begin
         optionWord[6] = 1'b1;
         if (!programmed[1]) begin
            optionWord[2] = 1'b0;
         end
      end
   end
endmodule : option_fuse_model

// file: dv/test_option_word_cycle_timing.sv
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module test_option_word_cycle_timing;
   timeunit 1ns;
   timeprecision 1ps;
   import option_word_pkg::*;

   logic mclk = 1'b0, rst_b = 1'b0, rawMode = 1'b0;
   logic [7:0] programmed = 8'h40, optionWord;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, configValid, optionFault, watchdogOn;
   logic voltageLevelSelect, packageSmall, externalRcMode, highCrystalMode, lowCrystalMode;
   logic cycleLen4, counterTick;
   logic [1:0] bresp, rresp;
   int n_errors = 0, checked = 0, retired = 0;

   // 8 ns oscillator period
   always #4 mclk = ~mclk;

   option_fuse_model fuse (.programmed(programmed), .rawMode(rawMode), .optionWord(optionWord));

   option_word_cycle_timing DUT (.mclk(mclk), .rst_b(rst_b), .optionWord(optionWord),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .configValid(configValid), .optionFault(optionFault), .watchdogOn(watchdogOn),
      .voltageLevelSelect(voltageLevelSelect), .packageSmall(packageSmall),
      .externalRcMode(externalRcMode), .highCrystalMode(highCrystalMode),
      .lowCrystalMode(lowCrystalMode), .cycleLen4(cycleLen4), .counterTick(counterTick));

   // single exit point for every outcome
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   // a bound that runs out is a failure, never a hang
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         n_errors++;
         print_verdict();
      end
   endtask : bound

   // write: address and data offered together, each released when taken
   task automatic axiWr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
      int n;
      bit aDone, wDone;
      n = 0;
      aDone = 0;
      wDone = 0;
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (awready === 1'b1 && !aDone) begin
            aDone = 1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !wDone) begin
            wDone = 1;
            wvalid <= 1'b0;
         end
      end while (bvalid !== 1'b1 && n < 200);
      bound(n, 200);
      r = bresp;
      // bready stays up, so a following write never drops and raises it at once
   endtask : axiWr

   // read: address held until taken, rready held until data seen
   task automatic axiRd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (arready === 1'b1) begin
            arvalid <= 1'b0;
         end
      end while (rvalid !== 1'b1 && n < 200);
      bound(n, 200);
      d = rdata;
      r = rresp;
      // rready stays up for the same reason as bready
   endtask : axiRd

   // edges until the next counter tick
   task automatic waitTick(output int n);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (counterTick !== 1'b1 && n < 20);
      bound(n, 20);
   endtask : waitTick

   // expected config register image of an option word
   function automatic logic [31:0] cfgExp(input logic [7:0] w);
      logic [1:0] m;
      m = !w[1] ? MODE_RC : (w[2] ? MODE_HIGH : MODE_LOW);
      return {26'h0, w[5], w[3], !w[4], m, w[0]};
   endfunction : cfgExp

   // reset with a new fuse pattern, then check every decoded output
   task automatic bootCheck(input logic [7:0] w, input logic raw);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      rst_b <= 1'b0;
      programmed <= w;
      rawMode <= raw;
      retired = 0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (configValid !== 1'b1 && n < 20);
      bound(n, 20);
      `CHK("fault", !w[6] || (!w[1] && w[2]), optionFault)
      `CHK("pkg", w[5], packageSmall)
      `CHK("wdt", !w[4], watchdogOn)
      `CHK("level", w[3], voltageLevelSelect)
      `CHK("rc", !w[1], externalRcMode)
      `CHK("high", w[1] && w[2], highCrystalMode)
      `CHK("low", w[1] && !w[2], lowCrystalMode)
      `CHK("len4", w[0], cycleLen4)
      axiRd(ADDR_CONFIG, d, r);
      `CHK("config", cfgExp(w), d)
      axiRd(ADDR_STATUS, d, r);
      // fault on bit 2, config valid on bit 1, idle on bit 0
      `CHK("status", {!w[6] || (!w[1] && w[2]), 1'b1, 1'b0}, d[2:0])
      // tick spacing equals instruction cycle length
      waitTick(n);
      waitTick(n);
      `CHK("tick", w[0] ? 4 : 2, n)
      // fuses disturbed mid-run must not reach the decoded state
      programmed <= ~w | 8'h40;
      rawMode <= 1'b1;
      repeat (6) @(posedge mclk);
      `CHK("held", cfgExp(w), {26'h0, packageSmall, voltageLevelSelect, watchdogOn,
         highCrystalMode, lowCrystalMode, cycleLen4})
   endtask : bootCheck

   // issue one instruction, wait for retirement, check count and cycles
   task automatic issue(input logic [12:0] ins, input logic sk, input logic [1:0] cy);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      axiWr(ADDR_INSTR, {15'h0, sk, 3'h0, ins}, 4'hF, r);
      `CHK("issue", RESP_OKAY, r)
      n = 0;
      do begin
         axiRd(ADDR_STATUS, d, r);
         n++;
      end while (d[ST_BUSY_BIT] !== 1'b0 && n < 50);
      bound(n, 50);
      retired++;
      `CHK("cycles", cy, d[5:4])
      axiRd(ADDR_RETIRED, d, r);
      `CHK("retired", retired[15:0], d[15:0])
      axiRd(ADDR_INSTR, d, r);
      `CHK("readback", {15'h0, sk, 3'h0, ins}, d)
   endtask : issue

   // instruction, skip outcome, expected instruction cycles
   logic [12:0] insT [25] = '{13'h0000, 13'h0042, 13'h0043, 13'h03C2, 13'h01C2, 13'h00C2,
      13'h0B82, 13'h0802, 13'h1000, 13'h1400, 13'h1C00, 13'h0012, 13'h0013, 13'h1E02,
      13'h1800, 13'h0E05, 13'h0E05, 13'h0C05, 13'h05C5, 13'h0585, 13'h07C5, 13'h0785,
      13'h0605, 13'h0046, 13'h0020};
   logic skT [25] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 1, 1, 1, 1, 1, 1, 1,
      0};
   logic [1:0] cyT [25] = '{1, 2, 1, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 1, 2, 1, 2, 2, 2, 2, 2,
      1, 1, 2};

   // hang guard
   initial begin
      repeat (90000) @(posedge mclk);
      n_errors++;
      print_verdict();
   end

   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      bootCheck(8'h40, 1'b0);
      for (int i = 0; i < 25; i++) begin
         issue(insT[i], skT[i], cyT[i]);
      end
      // refused accesses are answered with SLVERR
      axiWr(ADDR_CONFIG, 32'hFFFF_FFFF, 4'hF, r);
      `CHK("wr ro", RESP_SLVERR, r)
      axiWr(ADDR_INSTR, 32'h0000_1000, 4'h1, r);
      `CHK("wr strb", RESP_SLVERR, r)
      axiRd(5'h10, d, r);
      `CHK("rd unmapped", {RESP_SLVERR, 32'h0}, {r, d})
      bootCheck(8'hFF, 1'b0);
      // second issue while the first still runs is refused
      axiWr(ADDR_INSTR, 32'h0000_1000, 4'hF, r);
      axiWr(ADDR_INSTR, 32'h0000_0000, 4'hF, r);
      `CHK("busy", RESP_SLVERR, r)
      bootCheck(8'h43, 1'b0);
      issue(13'h0E05, 1'b1, CYCLES_TWO);
      bootCheck(8'h04, 1'b1);
      print_verdict();
   end
endmodule : test_option_word_cycle_timing
